// >>> psbw_pkg.sv
/*
 package of constants for the pseudo-static ram host controller.
 assumes a 250 MHz controller clock and an asynchronous 1M x 16 memory outside.
*/
// Functional notes
// - address changes only with cs or we high
// - never drive data while memory drives pins
// - keep write cycle within min and max
// - same-address write bursts total at most 10 us
// - read then write other lane, 10000 ns
// - write then read other lane, 10 us
// - each mixed cycle within own min/max
// - write cycle 85/95 ns min, 10000 ns max
package psbw_pkg;
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned WRITE_CYCLE_MIN_FAST_NS = 85;
   localparam int unsigned WRITE_CYCLE_MIN_SLOW_NS = 95;
   localparam int unsigned CYCLE_MAX_NS = 10000;
   localparam int unsigned SAME_ADDR_SUM_MAX_NS = 10000;
   localparam int unsigned SETUP_NS = 20;
   localparam int unsigned RECOVERY_NS = 20;
   localparam int unsigned DATA_HOLD_NS = 0;
   // least times round up, longest times round down
   localparam int unsigned WC_MIN_FAST_CYC = (WRITE_CYCLE_MIN_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WC_MIN_SLOW_CYC = (WRITE_CYCLE_MIN_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CYCLE_MAX_CYC = CYCLE_MAX_NS / CLK_PERIOD_NS;
   localparam int unsigned SUM_MAX_CYC = SAME_ADDR_SUM_MAX_NS / CLK_PERIOD_NS;
   localparam int unsigned SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RECOVERY_CYC = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned ADDR_W = 20;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned CNT_W = 14;
   typedef enum logic [2:0] {
      PSBW_IDLE,
      PSBW_SETUP,
      PSBW_WRITE,
      PSBW_READ,
      PSBW_RECOVER
   } psbw_state_t;
endpackage

// >>> psbw_host.sv
/*
 host controller for an asynchronous 1M x 16 pseudo-static ram.
 takes one request at a time (read or byte-lane write) and drives the memory pins.
 assumes the memory's data pins return through two synchronising flip-flops.
*/
`timescale 1ns/1ns
`default_nettype none
module psbw_host
   import psbw_pkg::*;
#(
   parameter int unsigned WC_MIN_CYC = WC_MIN_SLOW_CYC,
   parameter int unsigned SAME_ADDR_MAX_CYC = SUM_MAX_CYC
) (
   // clock and reset
   input wire logic MCLK_I,
   input wire logic RESETN_I,
   // user request
   input wire logic REQ_VALID_I,
   input wire logic REQ_WRITE_I,
   input wire logic [ADDR_W-1:0] REQ_ADDR_I,
   input wire logic [DATA_W-1:0] REQ_WDATA_I,
   input wire logic [1:0] REQ_LANE_I,
   output logic REQ_READY_O,
   output logic RSP_VALID_O,
   output logic [DATA_W-1:0] RSP_RDATA_O,
   // memory pins
   output logic [ADDR_W-1:0] MEM_ADDR_O,
   output logic MEM_CS_N_O,
   output logic MEM_WE_N_O,
   output logic MEM_OE_N_O,
   output logic LOW_BYTE_LANE_N_O,
   output logic HIGH_BYTE_LANE_N_O,
   output logic [DATA_W-1:0] MEM_DQ_O,
   output logic [DATA_W-1:0] MEM_DQ_OE_N_O,
   input wire logic [DATA_W-1:0] MEM_DQ_I
);
   psbw_state_t state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] burst_reg;
   logic burst_live_reg;
   logic [DATA_W-1:0] dq_meta_reg, dq_sync_reg;
   logic write_reg;
   logic [1:0] lane_reg;

   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   wire take = (state_reg == PSBW_IDLE) && REQ_VALID_I;
   // same address with cs held low continues a burst; its total is capped
   wire same_addr = burst_live_reg && (REQ_ADDR_I == MEM_ADDR_O);
   // checked one cycle before the idle slot: the next cycle adds setup, phase, recovery and two edges
   wire burst_room = (32'(burst_reg) + SETUP_CYC + WC_MIN_CYC + RECOVERY_CYC + 2) <= SAME_ADDR_MAX_CYC;
   wire cont_burst = same_addr && burst_room;
   wire cnt_done = (32'(cnt_reg) + 1) >= WC_MIN_CYC;
   wire setup_done = (32'(cnt_reg) + 1) >= SETUP_CYC;
   wire rec_done = (32'(cnt_reg) + 1) >= RECOVERY_CYC;
   wire [1:0] lane_n = ~lane_reg;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         PSBW_IDLE: if (take) state_next = PSBW_SETUP;
         PSBW_SETUP: if (setup_done) state_next = write_reg ? PSBW_WRITE : PSBW_READ;
         PSBW_WRITE: if (cnt_done) state_next = PSBW_RECOVER;
         PSBW_READ: if (cnt_done) state_next = PSBW_RECOVER;
         PSBW_RECOVER: if (rec_done) state_next = PSBW_IDLE;
      endcase
   end

   // -----------------------------------------------------------------
   // sequencing
   // -----------------------------------------------------------------
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         state_reg <= PSBW_IDLE;
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= (state_next != state_reg) ? '0 : cnt_reg + 1'b1;
      end
   end

   // burst time keeps running while cs stays low over same-address cycles
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         burst_reg <= '0;
         burst_live_reg <= 1'b0;
      end else if (take && MEM_CS_N_O) begin
         // cs went high in the idle slot, so the span count starts over
         burst_reg <= '0;
         burst_live_reg <= 1'b1;
      end else if (state_reg != PSBW_IDLE) begin
         burst_reg <= burst_reg + 1'b1;
      end else if (!REQ_VALID_I) begin
         burst_live_reg <= 1'b0; // idle: release cs, burst ends
      end else begin
         burst_reg <= burst_reg + 1'b1;
      end
   end

   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         write_reg <= 1'b0;
         lane_reg <= '0;
         MEM_ADDR_O <= '0;
         MEM_DQ_O <= '0;
      end else if (take) begin
         write_reg <= REQ_WRITE_I;
         lane_reg <= REQ_LANE_I;
         // address moves only in idle, where we is high and cs is high or stays idle
         MEM_ADDR_O <= REQ_ADDR_I;
         MEM_DQ_O <= REQ_WDATA_I;
      end
   end

   // -----------------------------------------------------------------
   // memory strobes
   // -----------------------------------------------------------------
   wire in_cycle = (state_next != PSBW_IDLE);
   wire hold_cs = (state_next == PSBW_IDLE) && burst_live_reg && REQ_VALID_I && cont_burst;
   wire we_next = !(state_next == PSBW_WRITE);
   wire oe_next = !(state_next == PSBW_READ);
   wire strobe = (state_next == PSBW_WRITE) || (state_next == PSBW_READ);

   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         MEM_CS_N_O <= 1'b1;
         MEM_WE_N_O <= 1'b1;
         MEM_OE_N_O <= 1'b1;
         LOW_BYTE_LANE_N_O <= 1'b1;
         HIGH_BYTE_LANE_N_O <= 1'b1;
         MEM_DQ_OE_N_O <= '1;
      end else begin
         MEM_CS_N_O <= !(in_cycle || hold_cs);
         MEM_WE_N_O <= we_next;
         MEM_OE_N_O <= oe_next;
         LOW_BYTE_LANE_N_O <= strobe ? lane_n[0] : 1'b1;
         HIGH_BYTE_LANE_N_O <= strobe ? lane_n[1] : 1'b1;
         // drive data only during the write phase, when oe is high
         MEM_DQ_OE_N_O <= (state_next == PSBW_WRITE) ? '0 : '1;
      end
   end

   // -----------------------------------------------------------------
   // read data return
   // -----------------------------------------------------------------
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         dq_meta_reg <= '0;
         dq_sync_reg <= '0;
         RSP_VALID_O <= 1'b0;
         RSP_RDATA_O <= '0;
         REQ_READY_O <= 1'b0;
      end else begin
         dq_meta_reg <= MEM_DQ_I;
         dq_sync_reg <= dq_meta_reg;
         REQ_READY_O <= (state_next == PSBW_IDLE);
         // sample at the end of the read; sync lag is covered by the cycle minimum
         RSP_VALID_O <= (state_reg == PSBW_READ) && cnt_done;
         if ((state_reg == PSBW_READ) && cnt_done) begin
            RSP_RDATA_O[7:0] <= lane_reg[0] ? dq_sync_reg[7:0] : 8'h00;
            RSP_RDATA_O[15:8] <= lane_reg[1] ? dq_sync_reg[15:8] : 8'h00;
         end
      end
   end
endmodule
`default_nettype wire

// >>> psbw_host_sva.sv
/* pin-timing checker for psbw_host.
 assumes it is bound into psbw_host and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module psbw_host_sva
   import psbw_pkg::*;
#(parameter int unsigned WC_MIN_CYC = 24, parameter int unsigned SAME_ADDR_MAX_CYC = 2500) (
   input wire logic MCLK_I, RESETN_I, REQ_READY_O, RSP_VALID_O,
   input wire logic MEM_CS_N_O, MEM_WE_N_O, MEM_OE_N_O, LOW_BYTE_LANE_N_O, HIGH_BYTE_LANE_N_O,
   input wire logic [ADDR_W-1:0] MEM_ADDR_O,
   input wire logic [DATA_W-1:0] MEM_DQ_OE_N_O);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RESETN_I);
   // cycle counters: write pulse length and cs-low span
   logic [CNT_W-1:0] wl_reg, cl_reg;
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         wl_reg <= '0;
         cl_reg <= '0;
      end else begin
         wl_reg <= MEM_WE_N_O ? '0 : wl_reg + 1'b1;
         cl_reg <= MEM_CS_N_O ? '0 : cl_reg + 1'b1;
      end
   end
   addr_move_a: assert property (!$stable(MEM_ADDR_O) |-> MEM_WE_N_O && $past(MEM_WE_N_O))
      else $error("address moved during write");
   bus_clash_a: assert property (!MEM_OE_N_O |-> &MEM_DQ_OE_N_O) else $error("data driven while reading");
   dq_release_a: assert property (~&MEM_DQ_OE_N_O |-> !MEM_WE_N_O) else $error("data driven outside write");
   low_lane_a: assert property (!MEM_WE_N_O && !LOW_BYTE_LANE_N_O |-> MEM_DQ_OE_N_O[7:0] == 8'h00)
      else $error("low lane not driven");
   high_lane_a: assert property (!MEM_WE_N_O && !HIGH_BYTE_LANE_N_O |-> MEM_DQ_OE_N_O[15:8] == 8'h00)
      else $error("high lane not driven");
   write_len_a: assert property ($rose(MEM_WE_N_O) |-> wl_reg == WC_MIN_CYC)
      else $error("write pulse length wrong");
   burst_cap_a: assert property (cl_reg <= SAME_ADDR_MAX_CYC) else $error("same-address span too long");
   read_rsp_a: assert property ($fell(MEM_OE_N_O) |-> ##[20:30] RSP_VALID_O) else $error("read answer late");
   idle_pins_a: assert property (REQ_READY_O |-> MEM_WE_N_O && MEM_OE_N_O) else $error("strobe active when idle");
   write_cs_a: assert property (!MEM_WE_N_O |-> !MEM_CS_N_O && MEM_OE_N_O) else $error("write without select");
   cover property ($fell(MEM_WE_N_O));
   cover property (RSP_VALID_O);
   cover property ($rose(MEM_CS_N_O) && $past(cl_reg) > 60);
endmodule
bind psbw_host psbw_host_sva #(.WC_MIN_CYC(WC_MIN_CYC), .SAME_ADDR_MAX_CYC(SAME_ADDR_MAX_CYC)) chk (
   .MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .REQ_READY_O(REQ_READY_O), .RSP_VALID_O(RSP_VALID_O),
   .MEM_CS_N_O(MEM_CS_N_O), .MEM_WE_N_O(MEM_WE_N_O), .MEM_OE_N_O(MEM_OE_N_O), .MEM_ADDR_O(MEM_ADDR_O),
   .LOW_BYTE_LANE_N_O(LOW_BYTE_LANE_N_O), .HIGH_BYTE_LANE_N_O(HIGH_BYTE_LANE_N_O), .MEM_DQ_OE_N_O(MEM_DQ_OE_N_O));
`default_nettype wire

// >>> psbw_mem_model.sv
/* behavioural 1M x 16 pseudo-static memory.
 assumes host data and enables arrive as split pins; returns the resolved bus. */
`timescale 1ns/1ns
`default_nettype none
module psbw_mem_model (
   input wire logic [19:0] a_i,
   input wire logic cs_n_i, we_n_i, oe_n_i, lo_n_i, hi_n_i,
   input wire logic [15:0] dq_i, dq_oe_n_i,
   output logic [15:0] bus_o);
   logic [7:0] lo_m [int];
   logic [7:0] hi_m [int];
   logic [15:0] fl = 16'hA55A;
   logic [15:0] rd;
   wire logic rd_en = !cs_n_i && we_n_i && !oe_n_i;
   // floating pins toggle so a stale value never passes
   always #3 fl = ~fl;
   always @* begin
      rd = fl;
      if (rd_en && !lo_n_i) rd[7:0] = lo_m[a_i];
      if (rd_en && !hi_n_i) rd[15:8] = hi_m[a_i];
      bus_o = (dq_i & ~dq_oe_n_i) | (rd & dq_oe_n_i);
   end
   always @* begin
      if (!cs_n_i && !we_n_i && !lo_n_i && !dq_oe_n_i[0]) lo_m[a_i] = dq_i[7:0];
      if (!cs_n_i && !we_n_i && !hi_n_i && !dq_oe_n_i[8]) hi_m[a_i] = dq_i[15:8];
   end
endmodule
`default_nettype wire

// >>> psbw_host_bench.sv
/* self-checking bench for psbw_host with a memory model.
 assumes the burst cap is shortened to 100 cycles. */
`timescale 1ns/1ns
`default_nettype none
module psbw_host_bench;
   logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, wr = 1'b0, rdy, rv, cs, we, oe, lb, hb;
   logic [1:0] lane = 2'h0;
   logic [19:0] addr = 20'h0, ma;
   logic [15:0] wd = 16'h0, rd, mdo, moe, mdi;
   int error_cnt = 0, checks = 0;
   logic [15:0] cs_run = 16'h0, cs_max = 16'h0;
   // longest run of cs low, to see that same-address requests kept it low
   always @(posedge clk) begin
      cs_run <= cs ? 16'h0 : cs_run + 16'h1;
      if (cs_run > cs_max) cs_max <= cs_run;
   end
   initial forever #2 clk = ~clk;
   psbw_host #(.SAME_ADDR_MAX_CYC(100)) uut (.MCLK_I(clk), .RESETN_I(rst_n), .REQ_VALID_I(vld), .REQ_WRITE_I(wr),
      .REQ_ADDR_I(addr), .REQ_WDATA_I(wd), .REQ_LANE_I(lane), .REQ_READY_O(rdy), .RSP_VALID_O(rv), .RSP_RDATA_O(rd),
      .MEM_ADDR_O(ma), .MEM_CS_N_O(cs), .MEM_WE_N_O(we), .MEM_OE_N_O(oe), .LOW_BYTE_LANE_N_O(lb),
      .HIGH_BYTE_LANE_N_O(hb), .MEM_DQ_O(mdo), .MEM_DQ_OE_N_O(moe), .MEM_DQ_I(mdi));
   psbw_mem_model mem (.a_i(ma), .cs_n_i(cs), .we_n_i(we), .oe_n_i(oe), .lo_n_i(lb), .hi_n_i(hb),
      .dq_i(mdo), .dq_oe_n_i(moe), .bus_o(mdi));
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t read %h want %h", $time, got, exp);
      end
   endtask
   // one request; a read is judged at its answer pulse
   task automatic op(input logic w_i, input logic [19:0] a_i, input logic [15:0] d_i, input logic [1:0] l_i,
      input logic [15:0] exp);
      int n;
      n = 0;
      do @(posedge clk); while (rdy !== 1'b1 && ++n < 500);
      if (n >= 500) error_cnt++;
      vld <= 1'b1;
      wr <= w_i;
      addr <= a_i;
      wd <= d_i;
      lane <= l_i;
      @(posedge clk);
      vld <= 1'b0;
      n = 0;
      if (!w_i) begin
         do @(posedge clk); while (rv !== 1'b1 && ++n < 100);
         chk(rd, exp);
      end
   endtask
   // same-address write with valid kept high, so it is taken straight after recovery
   task automatic held(input logic [15:0] d_i);
      int n;
      n = 0;
      vld <= 1'b1;
      wr <= 1'b1;
      addr <= 20'h00ABC;
      wd <= d_i;
      lane <= 2'h3;
      do @(posedge clk); while (rdy !== 1'b1 && ++n < 500);
      if (n >= 500) error_cnt++;
   endtask
   task automatic t_full;
      op(1'b1, 20'h12345, 16'hBEEF, 2'h3, 16'h0);
      op(1'b0, 20'h12345, 16'h0, 2'h3, 16'hBEEF);
      $display("t_full done");
   endtask
   task automatic t_lane;
      op(1'b1, 20'h12345, 16'h1177, 2'h1, 16'h0);
      op(1'b0, 20'h12345, 16'h0, 2'h3, 16'hBE77);
      op(1'b1, 20'h12345, 16'h55AA, 2'h2, 16'h0);
      op(1'b0, 20'h12345, 16'h0, 2'h1, 16'h0077);
      op(1'b0, 20'h12345, 16'h0, 2'h2, 16'h5500);
      $display("t_lane done");
   endtask
   task automatic t_burst;
      @(posedge clk);
      for (int i = 0; i < 6; i++) held(16'h1111 * i[15:0]);
      vld <= 1'b0;
      op(1'b0, 20'h00ABC, 16'h0, 2'h3, 16'h5555);
      chk({15'h0, (cs_max > 16'h003C) && (cs_max <= 16'h0064)}, 16'h0001);
      $display("t_burst done");
   endtask
   task automatic t_addr;
      op(1'b1, 20'h00001, 16'hA1A1, 2'h3, 16'h0);
      op(1'b1, 20'hFFFFF, 16'h5C3C, 2'h3, 16'h0);
      op(1'b0, 20'h00001, 16'h0, 2'h3, 16'hA1A1);
      op(1'b0, 20'hFFFFF, 16'h0, 2'h3, 16'h5C3C);
      $display("t_addr done");
   endtask
   initial begin
      #100000;
      error_cnt++;
      close_out();
   end
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_full();
      t_lane();
      t_burst();
      t_addr();
      close_out();
   end
endmodule
`default_nettype wire
